// File: src/blank_mask.sv
// Purpose: Comparator blanking source select and AND/OR gating
// Assumes: AHB-Lite single word transfers, PWM and fault inputs synchronous
// Notes: Blanking output and gated comparator are registered
// Function
// - 4-bit mask A selector: 0-5 PWM pair low/high, 15 fault A, else reserved
// - Bits 13, 11, 9 add true C, B, A levels to OR gate
// - Bits 12, 10, 8 add inverted C, B, A levels to OR gate
// - Bit 7 feeds inverted AND output into OR gate
// - Bit 6 feeds true AND output into OR gate
// - Bits 5..0 add true or inverted C, B, A levels to AND gate
`timescale 1ns/1ps
module blank_mask
  import blank_pkg::*;
(
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [7:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic hready, // Bus ready in
  input wire logic [31:0] hwdata, // Write data
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  input wire logic pwm_pair1_low, // PWM pair 1 low output
  input wire logic pwm_pair1_high, // PWM pair 1 high output
  input wire logic pwm_pair2_low, // PWM pair 2 low output
  input wire logic pwm_pair2_high, // PWM pair 2 high output
  input wire logic pwm_pair3_low, // PWM pair 3 low output
  input wire logic pwm_pair3_high, // PWM pair 3 high output
  input wire logic fault_input_a, // Fault input A
  input wire logic mask_input_b, // Mask B, selected outside
  input wire logic mask_input_c, // Mask C, selected outside
  input wire logic comp_raw, // Raw comparator output
  output logic blank_active, // Blanking signal, registered
  output logic comp_out // Comparator after blanking, registered
);
  import blank_pkg::*;

  logic [15:0] gate_ctrl_r;
  logic [15:0] src_sel_r;
  logic [31:0] hrdata_r;
  logic blank_r;
  logic comp_r;
  logic held_r;
  bus_state_t state_r;
  logic [7:0] addr_r;
  logic mask_input_a;
  logic mask_and_output;
  logic blank_nxt;
  logic [2:0] and_t;
  logic [2:0] or_t;
  logic [2:0] mlev;
  logic accept;
  logic block_now;

  assign accept = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign blank_active = blank_r;
  assign comp_out = comp_r;

  // Bus phase tracking, zero wait states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      addr_r <= 8'h00;
    end else if (hready) begin
      if (accept) begin
        state_r <= hwrite ? ST_WRITE : ST_READ;
        addr_r <= haddr;
      end else begin
        state_r <= ST_IDLE;
      end
    end
  end

  // Register writes in data phase; unmapped and reserved bits dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_ctrl_r <= GATE_CTRL_RST;
      src_sel_r <= SRC_SEL_RST;
    end else if (state_r == ST_WRITE) begin
      case (addr_r)
        GATE_CTRL_OFS: gate_ctrl_r <= hwdata[15:0] & GATE_CTRL_WMASK;
        SRC_SEL_OFS: src_sel_r <= hwdata[15:0] & SRC_SEL_WMASK;
        default: ;
      endcase
    end
  end

  // Read data latched at address phase, stands in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (accept && !hwrite) begin
      case (haddr)
        GATE_CTRL_OFS: hrdata_r <= {16'h0000, gate_ctrl_r};
        SRC_SEL_OFS: hrdata_r <= {16'h0000, src_sel_r};
        STATUS_OFS: hrdata_r <= {28'h0000000, held_r, mask_input_a, blank_r, comp_r};
        default: hrdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Mask A source; reserved codes give 0 so they never blank via true terms
  always_comb begin
    case (src_code_t'(src_sel_r[SRC_A_LSB +: SRC_W]))
      SRC_P1_LOW: mask_input_a = pwm_pair1_low;
      SRC_P1_HIGH: mask_input_a = pwm_pair1_high;
      SRC_P2_LOW: mask_input_a = pwm_pair2_low;
      SRC_P2_HIGH: mask_input_a = pwm_pair2_high;
      SRC_P3_LOW: mask_input_a = pwm_pair3_low;
      SRC_P3_HIGH: mask_input_a = pwm_pair3_high;
      SRC_FAULT_A: mask_input_a = fault_input_a;
      default: mask_input_a = 1'b0;
    endcase
  end

  assign mlev = {mask_input_c, mask_input_b, mask_input_a};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_term
      mask_gate_term #(.IS_AND(1'b1)) u_and (
        .level(mlev[gi]),
        .true_en(gate_ctrl_r[AND_A_TRUE_BIT + 2 * gi]),
        .inv_en(gate_ctrl_r[AND_A_INV_BIT + 2 * gi]),
        .term(and_t[gi])
      );
      mask_gate_term #(.IS_AND(1'b0)) u_or (
        .level(mlev[gi]),
        .true_en(gate_ctrl_r[OR_A_TRUE_BIT + 2 * gi]),
        .inv_en(gate_ctrl_r[OR_A_INV_BIT + 2 * gi]),
        .term(or_t[gi])
      );
    end
  endgenerate

  // Empty AND gate would read 1; treat as inactive so reset state never blanks
  assign mask_and_output = (|gate_ctrl_r[AND_C_TRUE_BIT:AND_A_INV_BIT]) & (&and_t);

  always_comb begin
    blank_nxt = |or_t;
    blank_nxt = blank_nxt | (gate_ctrl_r[AND_TRUE_SEL_BIT] & mask_and_output);
    blank_nxt = blank_nxt | (gate_ctrl_r[AND_INV_SEL_BIT] & ~mask_and_output);
  end

  // One blocking test shared by the hold flag and the output stage
  assign block_now = blank_nxt && (comp_raw == ~gate_ctrl_r[POL_BIT]);

  // Registered so a combinational glitch never reaches the output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blank_r <= 1'b0;
    end else begin
      blank_r <= blank_nxt;
    end
  end

  // Hold flag, visible to software through the status word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_r <= 1'b0;
    end else begin
      held_r <= block_now;
    end
  end

  // Blanked output holds its last value rather than passing an asserted level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comp_r <= 1'b0;
    end else if (!block_now) begin
      comp_r <= comp_raw;
    end
  end

  pol_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (blank_nxt && gate_ctrl_r[POL_BIT] && !comp_raw) |=> comp_out == $past(comp_out))
    else $error("low-asserted output passed while blanked");
  pol_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (blank_nxt && !gate_ctrl_r[POL_BIT] && comp_raw) |=> comp_out == $past(comp_out))
    else $error("high-asserted output passed while blanked");
  pass_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !blank_nxt |=> comp_out == $past(comp_raw))
    else $error("comparator not passed when not blanked");
  src_fault_a: assert property (@(posedge hclk) disable iff (!hresetn)
    src_sel_r[3:0] == 4'hF |-> mask_input_a == fault_input_a)
    else $error("fault source not selected");
  src_reserved_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (src_sel_r[3:0] > 4'h5 && src_sel_r[3:0] != 4'hF) |-> !mask_input_a)
    else $error("reserved source not quiet");
  or_a_true_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (gate_ctrl_r[9] && mask_input_a) |=> blank_active)
    else $error("true A term missing from blanking");
  or_c_inv_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (gate_ctrl_r[12] && !mask_input_c) |=> blank_active)
    else $error("inverted C term missing from blanking");
  and_true_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (gate_ctrl_r[6] && gate_ctrl_r[1] && gate_ctrl_r[5:2] == 4'h0 && mask_input_a) |=> blank_active)
    else $error("true AND output missing from blanking");
  and_inv_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (gate_ctrl_r[15:6] == 10'h002 && gate_ctrl_r[5:0] == 6'h01 && !mask_input_a) |=> !blank_active)
    else $error("inverted AND output wrongly blanked");
  reset_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
    gate_ctrl_r == 16'h0000 |=> !blank_active)
    else $error("blanking with all gating off");

  // Source codes 0 to 5 each route exactly their own candidate; reserved register bits stay 0
  src_p1_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    src_sel_r[3:0] == 4'h0
    |-> mask_input_a == pwm_pair1_low)
    else $error("pair 1 low source not selected");
  src_p1_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    src_sel_r[3:0] == 4'h1
    |-> mask_input_a == pwm_pair1_high)
    else $error("pair 1 high source not selected");
  src_p2_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    src_sel_r[3:0] == 4'h2
    |-> mask_input_a == pwm_pair2_low)
    else $error("pair 2 low source not selected");
  src_p2_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    src_sel_r[3:0] == 4'h3
    |-> mask_input_a == pwm_pair2_high)
    else $error("pair 2 high source not selected");
  src_p3_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    src_sel_r[3:0] == 4'h4
    |-> mask_input_a == pwm_pair3_low)
    else $error("pair 3 low source not selected");
  src_p3_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    src_sel_r[3:0] == 4'h5
    |-> mask_input_a == pwm_pair3_high)
    else $error("pair 3 high source not selected");
  reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1
    |-> (gate_ctrl_r[14] == 1'b0 && src_sel_r[15:4] == 12'h000))
    else $error("reserved register bits set");

  // OR gate terms, true and inverted, one input at a time
  or_a_inv_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (gate_ctrl_r[8] && !mask_input_a)
    |=> blank_active)
    else $error("inverted A term missing from blanking");
  or_b_true_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (gate_ctrl_r[11] && mask_input_b)
    |=> blank_active)
    else $error("true B term missing from blanking");
  or_b_inv_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (gate_ctrl_r[10] && !mask_input_b)
    |=> blank_active)
    else $error("inverted B term missing from blanking");
  or_c_true_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (gate_ctrl_r[13] && mask_input_c)
    |=> blank_active)
    else $error("true C term missing from blanking");
  or_a_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (gate_ctrl_r == 16'h0200 && !mask_input_a)
    |=> !blank_active)
    else $error("low A level blanked through true term");

  // AND gate terms seen through the true AND select
  and_b_inv_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (gate_ctrl_r == 16'h0044 && !mask_input_b)
    |=> blank_active)
    else $error("inverted B AND term missing");
  and_b_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (gate_ctrl_r == 16'h0044 && mask_input_b)
    |=> !blank_active)
    else $error("inverted B AND term passed a high level");
  and_c_inv_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (gate_ctrl_r == 16'h0050 && !mask_input_c)
    |=> blank_active)
    else $error("inverted C AND term missing");
  and_c_true_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (gate_ctrl_r == 16'h0060 && mask_input_c)
    |=> blank_active)
    else $error("true C AND term missing");
  // Empty AND gate reads 0, so its inverse always blanks
  and_inv_empty_a: assert property (@(posedge hclk) disable iff (!hresetn)
    gate_ctrl_r == 16'h0080
    |=> blank_active)
    else $error("inverted empty AND output not blanking");
  and_true_empty_a: assert property (@(posedge hclk) disable iff (!hresetn)
    gate_ctrl_r == 16'h0040
    |=> !blank_active)
    else $error("empty AND output blanking");

  // Non-asserted levels always pass whatever the blanking state
  pass_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (gate_ctrl_r[POL_BIT] && comp_raw)
    |=> comp_out)
    else $error("high level blocked under low polarity");
  pass_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!gate_ctrl_r[POL_BIT] && !comp_raw)
    |=> !comp_out)
    else $error("low level blocked under high polarity");

  blank_seen_c: cover property (@(posedge hclk) disable iff (!hresetn) blank_active);
  held_low_c: cover property (@(posedge hclk) disable iff (!hresetn) held_r && gate_ctrl_r[POL_BIT]);
  held_high_c: cover property (@(posedge hclk) disable iff (!hresetn) held_r && !gate_ctrl_r[POL_BIT]);
  and_path_c: cover property (@(posedge hclk) disable iff (!hresetn) mask_and_output && gate_ctrl_r[6]);
  fault_src_c: cover property (@(posedge hclk) disable iff (!hresetn) src_sel_r[3:0] == 4'hF && mask_input_a);
endmodule // blank_mask

// File: src/blank_pkg.sv
// Purpose: Constants for the comparator blanking and mask logic
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes: Register offsets are chosen locally
package blank_pkg;
  localparam logic [7:0] GATE_CTRL_OFS = 8'h00;
  localparam logic [7:0] SRC_SEL_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [15:0] GATE_CTRL_RST = 16'h0000;
  localparam logic [15:0] SRC_SEL_RST = 16'h0000;
  localparam logic [15:0] GATE_CTRL_WMASK = 16'hBFFF;
  localparam logic [15:0] SRC_SEL_WMASK = 16'h000F;
  localparam int POL_BIT = 15;
  localparam int OR_C_TRUE_BIT = 13;
  localparam int OR_C_INV_BIT = 12;
  localparam int OR_B_TRUE_BIT = 11;
  localparam int OR_B_INV_BIT = 10;
  localparam int OR_A_TRUE_BIT = 9;
  localparam int OR_A_INV_BIT = 8;
  localparam int AND_INV_SEL_BIT = 7;
  localparam int AND_TRUE_SEL_BIT = 6;
  localparam int AND_C_TRUE_BIT = 5;
  localparam int AND_C_INV_BIT = 4;
  localparam int AND_B_TRUE_BIT = 3;
  localparam int AND_B_INV_BIT = 2;
  localparam int AND_A_TRUE_BIT = 1;
  localparam int AND_A_INV_BIT = 0;
  localparam int SRC_A_LSB = 0;
  localparam int SRC_W = 4;
  typedef enum logic [3:0] {
    SRC_P1_LOW = 4'b0000,
    SRC_P1_HIGH = 4'b0001,
    SRC_P2_LOW = 4'b0010,
    SRC_P2_HIGH = 4'b0011,
    SRC_P3_LOW = 4'b0100,
    SRC_P3_HIGH = 4'b0101,
    SRC_FAULT_A = 4'b1111
  } src_code_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_READ = 2'b10
  } bus_state_t;
endpackage

// File: src/mask_gate_term.sv
// Purpose: One enabled true and inverted term pair of a mask gate
// Assumes: Purely combinational
// Notes: Neutral value given when disabled
`timescale 1ns/1ps
module mask_gate_term #(
  parameter bit IS_AND = 1'b0 // AND gate term when set
) (
  input wire logic level, // Mask input level
  input wire logic true_en, // True term enable
  input wire logic inv_en, // Inverted term enable
  output logic term // Combined contribution
);
  // AND neutral is 1, OR neutral is 0
  always_comb begin
    if (IS_AND) begin
      term = (~true_en | level) & (~inv_en | ~level);
    end else begin
      term = (true_en & level) | (inv_en & ~level);
    end
  end
endmodule // mask_gate_term

// File: verification/pwm_fault_model.sv
// Purpose: Behavioural PWM generator and fault source feeding the mask A candidates
// Assumes: Levels change just after a rising clock edge, as real PWM flops do
// Notes: All lines low in reset, the idle state of the PWM outputs
`timescale 1ns/1ps
module pwm_fault_model (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Async reset, active low
  input wire logic [6:0] pattern, // Requested levels, fault A in bit 6
  output logic [6:0] lines // Pair 1 low/high, pair 2, pair 3, then fault A
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lines <= 7'h00;
    end else begin
      lines <= pattern;
    end
  end
endmodule // pwm_fault_model

// File: verification/tb_blank_mask.sv
// Purpose: Self-checking bench for the comparator blanking and mask logic
// Assumes: Zero-wait AHB-Lite slave, partner adds one register stage
// Notes: Rows cover source codes and gating, hand tests cover reset, fields and hold
`timescale 1ns/1ps
module tb_blank_mask;
  import blank_pkg::*;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [3:0] src;
    logic [6:0] pat;
    logic b;
    logic c;
    logic e;
  } row_t;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, blank_active, comp_out;
  logic [6:0] pat = 7'h00;
  logic [6:0] lines;
  logic mask_b = 1'h0;
  logic mask_c = 1'h0;
  logic comp_raw = 1'h0;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  row_t rows[$];
  always #12.5 hclk = ~hclk;
  pwm_fault_model pwm_fault_model_inst (.hclk(hclk), .hresetn(hresetn), .pattern(pat), .lines(lines));
  blank_mask blank_mask_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pwm_pair1_low(lines[0]), .pwm_pair1_high(lines[1]),
    .pwm_pair2_low(lines[2]), .pwm_pair2_high(lines[3]), .pwm_pair3_low(lines[4]),
    .pwm_pair3_high(lines[5]), .fault_input_a(lines[6]), .mask_input_b(mask_b), .mask_input_c(mask_c),
    .comp_raw(comp_raw), .blank_active(blank_active), .comp_out(comp_out));
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Hang guard, the whole run needs well under a thousand cycles
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] rd;
    bus(1'h1, a, {16'h0000, d}, rd);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'h0, a, 32'h0, rd);
    check(name, rd, exp);
  endtask
  // Partner stage plus the registered output: two edges, one spare
  task automatic settle();
    repeat (3) @(posedge hclk);
    #1;
  endtask
  task automatic step(input logic raw, input logic e);
    comp_raw <= raw;
    settle();
    check("comp_out", {31'h0, comp_out}, {31'h0, e});
  endtask
  task automatic add(input logic [15:0] ct, input logic [3:0] s, input logic [6:0] p, input logic b,
    input logic c, input logic e);
    rows.push_back('{ct, s, p, b, c, e});
  endtask
  initial begin
    for (int k = 0; k < 6; k++) add(16'h0200, k[3:0], 7'h01 << k, 1'h0, 1'h0, 1'h1);
    add(16'h0200, 4'hF, 7'h40, 1'h0, 1'h0, 1'h1);
    add(16'h0200, 4'h1, 7'h7D, 1'h0, 1'h0, 1'h0);
    add(16'h0200, 4'h6, 7'h7F, 1'h0, 1'h0, 1'h0);
    add(16'h0100, 4'h0, 7'h00, 1'h0, 1'h0, 1'h1);
    add(16'h0100, 4'h0, 7'h01, 1'h0, 1'h0, 1'h0);
    add(16'h0800, 4'h0, 7'h00, 1'h1, 1'h0, 1'h1);
    add(16'h0800, 4'h0, 7'h00, 1'h0, 1'h1, 1'h0);
    add(16'h2000, 4'h0, 7'h00, 1'h0, 1'h1, 1'h1);
    add(16'h0400, 4'h0, 7'h00, 1'h0, 1'h0, 1'h1);
    add(16'h1000, 4'h0, 7'h00, 1'h0, 1'h1, 1'h0);
    add(16'h1000, 4'h0, 7'h00, 1'h0, 1'h0, 1'h1);
    add(16'h004A, 4'h0, 7'h01, 1'h1, 1'h0, 1'h1);
    add(16'h004A, 4'h0, 7'h01, 1'h0, 1'h0, 1'h0);
    add(16'h00A2, 4'h0, 7'h01, 1'h0, 1'h1, 1'h0);
    add(16'h00A2, 4'h0, 7'h01, 1'h0, 1'h0, 1'h1);
    add(16'h0055, 4'h0, 7'h00, 1'h0, 1'h0, 1'h1);
    add(16'h0055, 4'h0, 7'h00, 1'h1, 1'h0, 1'h0);
    add(16'h0040, 4'h0, 7'h7F, 1'h1, 1'h1, 1'h0);
    add(16'h0080, 4'h0, 7'h7F, 1'h1, 1'h1, 1'h1);
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    #1;
    check("blank_active reset", {31'h0, blank_active}, 32'h0);
    check("comp_out reset", {31'h0, comp_out}, 32'h0);
    check("hresp", {31'h0, hresp}, 32'h0);
    rd_chk("gate reset", GATE_CTRL_OFS, 32'h0);
    rd_chk("source reset", SRC_SEL_OFS, 32'h0);
    wr_reg(GATE_CTRL_OFS, 16'hFFFF);
    rd_chk("gate fields", GATE_CTRL_OFS, 32'h0000BFFF);
    wr_reg(SRC_SEL_OFS, 16'hFFFF);
    rd_chk("source fields", SRC_SEL_OFS, 32'h0000000F);
    rd_chk("unmapped", 8'h0C, 32'h0);
    foreach (rows[i]) begin
      wr_reg(GATE_CTRL_OFS, rows[i].ctrl);
      wr_reg(SRC_SEL_OFS, {12'h000, rows[i].src});
      pat <= rows[i].pat;
      mask_b <= rows[i].b;
      mask_c <= rows[i].c;
      settle();
      check($sformatf("blank row %0d", i), {31'h0, blank_active}, {31'h0, rows[i].e});
    end
    pat <= 7'h00;
    wr_reg(SRC_SEL_OFS, 16'h0000);
    wr_reg(GATE_CTRL_OFS, 16'h0000);
    step(1'h0, 1'h0);
    wr_reg(GATE_CTRL_OFS, 16'h0100);
    step(1'h1, 1'h0);
    step(1'h0, 1'h0);
    wr_reg(GATE_CTRL_OFS, 16'h8100);
    step(1'h1, 1'h1);
    step(1'h0, 1'h1);
    rd_chk("status", STATUS_OFS, 32'h0000000B);
    check("hreadyout", {31'h0, hreadyout}, 32'h1);
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    #1;
    check("blank_active rerun", {31'h0, blank_active}, 32'h0);
    check("comp_out rerun", {31'h0, comp_out}, 32'h0);
    rd_chk("gate rerun", GATE_CTRL_OFS, 32'h0);
    rd_chk("source rerun", SRC_SEL_OFS, 32'h0);
    finish_test();
  end
endmodule // tb_blank_mask
